// ### pkg/fws_pkg.sv
package fws_pkg;

   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] WRITE_LATCH_SET_CMD   = 8'h06;
   localparam logic [7:0] WRITE_LATCH_CLEAR_CMD = 8'h04;
   localparam logic [7:0] STATUS_READ_CMD       = 8'h05;
   localparam logic [7:0] CONFIG_READ_CMD       = 8'h15;
   localparam logic [7:0] IDENTITY_READ_CMD     = 8'h9f;
   localparam logic [7:0] STATUS_WRITE_CMD      = 8'h01;
   localparam logic [7:0] PAGE_PROGRAM_CMD      = 8'h02;
   localparam logic [7:0] QUAD_PAGE_PROGRAM_CMD = 8'h38;
   localparam logic [7:0] FOUR_KB_WIPE_CMD      = 8'h20;
   localparam logic [7:0] HALF_BLOCK_WIPE_CMD   = 8'h52;
   localparam logic [7:0] BLOCK_WIPE_CMD        = 8'hd8;
   localparam logic [7:0] CHIP_WIPE_CMD_A       = 8'h60;
   localparam logic [7:0] CHIP_WIPE_CMD_B       = 8'hc7;
   localparam logic [7:0] SUSPEND_CMD_A         = 8'h75;
   localparam logic [7:0] SUSPEND_CMD_B         = 8'hb0;
   localparam logic [7:0] RESET_ARM_CMD         = 8'h66;
   localparam logic [7:0] RESET_GO_CMD          = 8'h99;
   localparam logic [7:0] SECURITY_LOCK_WRITE_CMD = 8'h2f;

   // ----------------------------------------------------------------
   // status byte layout and reset values
   // ----------------------------------------------------------------
   localparam int ST_BUSY    = 0;
   localparam int ST_WEL     = 1;
   localparam int ST_PL_LO   = 2;
   localparam int ST_PL_HI   = 5;
   localparam int ST_QE      = 6;
   localparam int ST_LOCK    = 7;
   localparam logic [3:0] PROTECT_LEVEL_RST = 4'h0;
   localparam logic       QUAD_ENABLE_RST   = 1'b0;
   localparam logic       WRITE_LOCK_RST    = 1'b0;

   // arbitrary identity and configuration values
   localparam logic [23:0] ID_CODE_DEF  = 24'h5a_a5_3c;
   localparam logic [7:0]  CFG_BYTE_DEF = 8'h00;

   // ----------------------------------------------------------------
   // framing counts
   // ----------------------------------------------------------------
   localparam logic [2:0] BIT_FIRST       = 3'h0;
   localparam logic [2:0] BIT_LAST        = 3'h7;
   localparam logic [1:0] LIDX_MAX        = 2'h3;
   localparam logic [2:0] NB_OPCODE_ONLY  = 3'h1;
   localparam logic [2:0] NB_STATUS_WRITE = 3'h2;
   localparam logic [2:0] NB_ADDR_CMD     = 3'h4;
   localparam logic [2:0] NB_MAX          = 3'h7;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int PE_TIME_NS    = 50000;
   localparam int SW_TIME_NS    = 20000;
   localparam int PE_CYCLES_DEF = (PE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SW_CYCLES_DEF = (SW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TMR_W         = 16;

   typedef enum logic [1:0] {
      FWS_IDLE   = 2'b00,
      FWS_RUN_PE = 2'b01,
      FWS_RUN_SW = 2'b10
   } fws_state_t;

endpackage : fws_pkg

// ### logic/fws_sync.sv
`timescale 1ns/1ns
module fws_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff <= RST_VAL;
         q_ff    <= RST_VAL;
      end else begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule : fws_sync

// ### logic/fws_timer.sv
`timescale 1ns/1ns
module fws_timer #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   input  wire logic         abort,
   output logic              done
);
   localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
   localparam logic [W-1:0] ZERO = '0;

   logic [W-1:0] count_ff;

   always_ff @(posedge clk) begin
      if (rst || abort) begin
         count_ff <= ZERO;
      end else if (load) begin
         count_ff <= load_val;
      end else if (count_ff != ZERO) begin
         count_ff <= count_ff - ONE;
      end
   end

   // last count of a running cycle
   assign done = (count_ff == ONE) && !abort && !load;
endmodule : fws_timer

// ### logic/fws_flash_core.sv
`timescale 1ns/1ns
// Summary of operation
// - latch set command sets write latch when not busy
// - upper io lines ignored during shifting
// - latch clear command clears write latch
// - latch cleared at power-up and completions
// - writes ignored unless latch was set
// - identity read returns three bytes, then zeros
// - identity read ignored while busy
// - status read any time, repeats
// - config read any time
// - busy bit zero set during cycles
// - write latch bit one, cleared on completion
// - chip wipe ignored when protect level nonzero, latch cleared
// - protect level bits, chip wipe needs zero
// - quad enable zero blocks quad commands
// - quad enable one disables hardware lock
// - lock with protect low rejects status write
// - status write leaves busy and latch
// - status write needs byte boundary end
// - soft reset only right after arm
module fws_flash_core
   import fws_pkg::*;
#(
   parameter int          PE_CYCLES = fws_pkg::PE_CYCLES_DEF,
   parameter int          SW_CYCLES = fws_pkg::SW_CYCLES_DEF,
   parameter logic [23:0] ID_CODE   = fws_pkg::ID_CODE_DEF,
   parameter logic [7:0]  CFG_BYTE  = fws_pkg::CFG_BYTE_DEF
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       sclk,
   input  wire logic       select_n,
   input  wire logic       si,
   input  wire logic [2:0] upper_io_lines,
   output logic            so_out,
   output logic            so_oe
);
   import fws_pkg::*;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic is_chip_wipe(input logic [7:0] op);
      is_chip_wipe = (op == CHIP_WIPE_CMD_A) || (op == CHIP_WIPE_CMD_B);
   endfunction : is_chip_wipe

   function automatic logic is_prog_erase(input logic [7:0] op);
      is_prog_erase = (op == PAGE_PROGRAM_CMD) || (op == QUAD_PAGE_PROGRAM_CMD) ||
                      (op == FOUR_KB_WIPE_CMD) || (op == HALF_BLOCK_WIPE_CMD) ||
                      (op == BLOCK_WIPE_CMD) || is_chip_wipe(op);
   endfunction : is_prog_erase

   // ----------------------------------------------------------------
   // link domain: serial clock
   // ----------------------------------------------------------------
   logic       first_ff;
   logic [2:0] bit_cnt_ff;
   logic [7:0] rx_sr_ff;
   logic [7:0] rx_byte_ff;
   logic [7:0] opc_l_ff;
   logic [7:0] tx_byte_ff;
   logic [1:0] lidx_ff;
   logic       tgl_ff;
   logic       part_ff;
   logic       tx_on_ff;
   logic       so_ff;
   logic       so_oe_ff;
   logic [7:0] st_l;
   logic [7:0] status_ff;

   // status bits cross bit by bit; each is a slow independent flag
   fws_sync #(
      .W       (8),
      .RST_VAL (8'h00)
   ) u_st_sync (
      .clk (sclk),
      .rst (rst),
      .d   (status_ff),
      .q   (st_l)
   );

   wire [2:0] cur_cnt   = first_ff ? BIT_FIRST : bit_cnt_ff;
   wire       byte_done = (cur_cnt == BIT_LAST);
   wire [7:0] new_byte  = {rx_sr_ff[6:0], si};
   wire [1:0] cur_idx   = first_ff ? 2'h0 : lidx_ff;
   wire [7:0] cur_op    = (cur_idx == 2'h0) ? new_byte : opc_l_ff;

   wire rd_status = (cur_op == STATUS_READ_CMD);
   wire rd_cfg    = (cur_op == CONFIG_READ_CMD);
   // busy is judged at the opcode only; a busy end mid-frame starts no output
   wire rd_id     = (cur_op == IDENTITY_READ_CMD) &&
                    ((cur_idx == 2'h0) ? !st_l[ST_BUSY] : tx_on_ff);

   wire [7:0] id_byte = (cur_idx == 2'h0) ? ID_CODE[23:16] :
                        (cur_idx == 2'h1) ? ID_CODE[15:8]  :
                        (cur_idx == 2'h2) ? ID_CODE[7:0]   : 8'h00;

   wire [7:0] nxt_tx_byte = rd_status ? st_l : (rd_cfg ? CFG_BYTE : id_byte);
   wire       nxt_tx_on   = rd_status || rd_cfg || rd_id;

   // frame start marker; held set while deselected
   always_ff @(posedge sclk or posedge select_n) begin
      if (select_n) begin
         first_ff <= 1'b1;
      end else begin
         first_ff <= 1'b0;
      end
   end

   // sclk may never tick during rst, so this domain resets asynchronously
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         bit_cnt_ff <= BIT_FIRST;
         rx_sr_ff   <= 8'h00;
         rx_byte_ff <= 8'h00;
         opc_l_ff   <= 8'h00;
         tx_byte_ff <= 8'h00;
         lidx_ff    <= 2'h0;
         tgl_ff     <= 1'b0;
         part_ff    <= 1'b0;
      end else begin
         bit_cnt_ff <= cur_cnt + 3'h1;
         rx_sr_ff   <= new_byte;
         part_ff    <= !byte_done;
         if (byte_done) begin
            rx_byte_ff <= new_byte;
            tgl_ff     <= ~tgl_ff;
            lidx_ff    <= (cur_idx == LIDX_MAX) ? LIDX_MAX : cur_idx + 2'h1;
            tx_byte_ff <= nxt_tx_byte;
            if (cur_idx == 2'h0) begin
               opc_l_ff <= new_byte;
            end
         end else begin
            lidx_ff <= cur_idx;
         end
      end
   end

   always_ff @(posedge sclk or posedge select_n) begin
      if (select_n) begin
         tx_on_ff <= 1'b0;
      end else if (byte_done) begin
         tx_on_ff <= nxt_tx_on;
      end
   end

   // output changes on the falling edge, cut at once on deselect
   always_ff @(negedge sclk or posedge select_n) begin
      if (select_n) begin
         so_ff    <= 1'b0;
         so_oe_ff <= 1'b0;
      end else begin
         so_ff    <= tx_byte_ff[~bit_cnt_ff];
         so_oe_ff <= tx_on_ff;
      end
   end

   assign so_out = so_ff;
   assign so_oe  = so_oe_ff;

   // ----------------------------------------------------------------
   // crossing into the system clock
   // ----------------------------------------------------------------
   logic [3:0] sys_s;
   logic       sel_d_ff;
   logic       tgl_d_ff;
   logic       end_ff;

   fws_sync #(
      .W       (4),
      .RST_VAL (4'hc)
   ) u_sys_sync (
      .clk (clk),
      .rst (rst),
      .d   ({upper_io_lines[1], select_n, tgl_ff, part_ff}),
      .q   (sys_s)
   );

   // write protect is only looked at when a command commits
   wire wp_n_s    = sys_s[3];
   wire sel_s     = sys_s[2];
   wire tgl_s     = sys_s[1];
   wire part_s    = sys_s[0];
   wire byte_evt  = tgl_s ^ tgl_d_ff;
   wire frame_end = sel_s && !sel_d_ff;

   // ----------------------------------------------------------------
   // command capture
   // ----------------------------------------------------------------
   logic [2:0] nbytes_ff;
   logic [7:0] op_ff;
   logic [7:0] dat_ff;

   // commit waits a cycle so a last byte seen with deselect is counted
   always_ff @(posedge clk) begin
      if (rst) begin
         sel_d_ff  <= 1'b1;
         tgl_d_ff  <= 1'b0;
         end_ff    <= 1'b0;
         nbytes_ff <= 3'h0;
         op_ff     <= 8'h00;
         dat_ff    <= 8'h00;
      end else begin
         sel_d_ff <= sel_s;
         tgl_d_ff <= tgl_s;
         end_ff   <= frame_end;
         if (end_ff) begin
            nbytes_ff <= 3'h0;
            op_ff     <= 8'h00;
         end else if (byte_evt) begin
            nbytes_ff <= (nbytes_ff == NB_MAX) ? NB_MAX : nbytes_ff + 3'h1;
            if (nbytes_ff == 3'h0) begin
               op_ff <= rx_byte_ff;
            end
            if (nbytes_ff == NB_OPCODE_ONLY) begin
               dat_ff <= rx_byte_ff;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // status bits and command execution
   // ----------------------------------------------------------------
   fws_state_t state_ff;
   fws_state_t nxt_state;
   logic       wel_ff;
   logic       nxt_wel;
   logic [3:0] prot_ff;
   logic [3:0] nxt_prot;
   logic       qe_ff;
   logic       nxt_qe;
   logic       lock_ff;
   logic       nxt_lock;
   logic [5:0] pend_ff;
   logic [5:0] nxt_pend;
   logic       armed_ff;
   logic       nxt_armed;
   logic       tmr_done;

   wire busy      = (state_ff != FWS_IDLE);
   wire hw_lock   = lock_ff && !wp_n_s && !qe_ff;
   wire on_bound  = !part_s;
   wire ce_op     = is_chip_wipe(op_ff);
   wire pe_len_ok = ce_op ? (nbytes_ff == NB_OPCODE_ONLY) : (nbytes_ff == NB_ADDR_CMD);
   wire quad_bad  = (op_ff == QUAD_PAGE_PROGRAM_CMD) && !qe_ff;
   wire ce_prot   = ce_op && (prot_ff != PROTECT_LEVEL_RST);
   wire pe_try    = is_prog_erase(op_ff) && wel_ff && !busy && pe_len_ok;
   wire want_pe   = pe_try && !quad_bad && !ce_prot;
   wire want_sw   = (op_ff == STATUS_WRITE_CMD) && wel_ff && !busy && on_bound &&
                    (nbytes_ff >= NB_STATUS_WRITE) && !hw_lock;
   wire susp_op   = (op_ff == SUSPEND_CMD_A) || (op_ff == SUSPEND_CMD_B);
   wire rst_go    = (op_ff == RESET_GO_CMD) && armed_ff;
   wire tmr_load  = end_ff && (want_pe || want_sw);
   wire tmr_abort = end_ff && ((susp_op && busy) || rst_go);

   fws_timer #(
      .W (TMR_W)
   ) u_timer (
      .clk      (clk),
      .rst      (rst),
      .load     (tmr_load),
      .load_val (want_sw ? TMR_W'(SW_CYCLES) : TMR_W'(PE_CYCLES)),
      .abort    (tmr_abort),
      .done     (tmr_done)
   );

   always_comb begin
      nxt_state = state_ff;
      nxt_wel   = wel_ff;
      nxt_prot  = prot_ff;
      nxt_qe    = qe_ff;
      nxt_lock  = lock_ff;
      nxt_pend  = pend_ff;
      nxt_armed = armed_ff;
      if (tmr_done) begin
         nxt_state = FWS_IDLE;
         nxt_wel   = 1'b0;
         if (state_ff == FWS_RUN_SW) begin
            // only bits above the latch take the written data
            nxt_prot = pend_ff[ST_PL_HI-2:ST_PL_LO-2];
            nxt_qe   = pend_ff[ST_QE-2];
            nxt_lock = pend_ff[ST_LOCK-2];
         end
      end
      if (end_ff) begin
         nxt_armed = (op_ff == RESET_ARM_CMD);
         case (op_ff)
            WRITE_LATCH_SET_CMD: begin
               if (!busy) begin
                  nxt_wel = 1'b1;
               end
            end
            WRITE_LATCH_CLEAR_CMD: begin
               nxt_wel = 1'b0;
            end
            STATUS_WRITE_CMD: begin
               if (want_sw) begin
                  nxt_state = FWS_RUN_SW;
                  nxt_pend  = dat_ff[ST_LOCK:ST_PL_LO];
               end
            end
            SECURITY_LOCK_WRITE_CMD: begin
               if (wel_ff && !busy) begin
                  nxt_wel = 1'b0;
               end
            end
            RESET_GO_CMD: begin
               if (rst_go) begin
                  nxt_state = FWS_IDLE;
                  nxt_wel   = 1'b0;
               end
            end
            default: begin
               if (susp_op && busy) begin
                  nxt_state = FWS_IDLE;
                  nxt_wel   = 1'b0;
               end else if (want_pe) begin
                  nxt_state = FWS_RUN_PE;
               end else if (pe_try && ce_prot) begin
                  nxt_wel = 1'b0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff  <= FWS_IDLE;
         wel_ff    <= 1'b0;
         prot_ff   <= PROTECT_LEVEL_RST;
         qe_ff     <= QUAD_ENABLE_RST;
         lock_ff   <= WRITE_LOCK_RST;
         pend_ff   <= 6'h00;
         armed_ff  <= 1'b0;
         status_ff <= 8'h00;
      end else begin
         state_ff  <= nxt_state;
         wel_ff    <= nxt_wel;
         prot_ff   <= nxt_prot;
         qe_ff     <= nxt_qe;
         lock_ff   <= nxt_lock;
         pend_ff   <= nxt_pend;
         armed_ff  <= nxt_armed;
         status_ff <= {nxt_lock, nxt_qe, nxt_prot, nxt_wel, nxt_state != FWS_IDLE};
      end
   end

endmodule : fws_flash_core

// ### verification/fws_core_checker.sv
`timescale 1ns/1ns
module fws_core_checker
   import fws_pkg::*;
#(
   parameter logic [23:0] ID_CODE  = fws_pkg::ID_CODE_DEF,
   parameter logic [7:0]  CFG_BYTE = fws_pkg::CFG_BYTE_DEF
) (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       sclk,
   input wire logic       select_n,
   input wire logic       si,
   input wire logic [2:0] upper_io_lines,
   input wire logic       so_out,
   input wire logic       so_oe
);
   logic [7:0] nbit_ff;
   logic [7:0] op_ff;
   wire        rd_cmd;
   wire        wr_cmd;
   assign rd_cmd = (op_ff == STATUS_READ_CMD) || (op_ff == CONFIG_READ_CMD);
   assign wr_cmd = (op_ff == WRITE_LATCH_SET_CMD) || (op_ff == WRITE_LATCH_CLEAR_CMD);

   // ----------------------------------------------------------------
   // bit count per frame, cleared by deselect like the link logic
   // ----------------------------------------------------------------
   always_ff @(posedge sclk or posedge select_n) begin
      if (select_n) begin
         nbit_ff <= 8'h00;
         op_ff   <= 8'h00;
      end else begin
         nbit_ff <= (nbit_ff == 8'hff) ? nbit_ff : nbit_ff + 8'h01;
         op_ff   <= (nbit_ff < 8'h08) ? {op_ff[6:0], si} : op_ff;
      end
   end

   a_oe_deselect: assert property (@(posedge clk) disable iff (rst)
      select_n && $past(select_n) |-> !so_oe) else $error("so_oe high while deselected");
   a_so_deselect: assert property (@(posedge clk) disable iff (rst)
      select_n && $past(select_n) |-> !so_out) else $error("so_out high while deselected");
   a_read_start: assert property (@(posedge sclk) disable iff (rst || select_n)
      nbit_ff == 8'h08 && rd_cmd |-> so_oe) else $error("read answer not started");
   a_write_quiet: assert property (@(posedge clk) disable iff (rst)
      !select_n && nbit_ff >= 8'h08 && wr_cmd |-> !so_oe)
      else $error("output on a latch command");
   a_cfg_value: assert property (@(posedge sclk) disable iff (rst || select_n)
      op_ff == CONFIG_READ_CMD && nbit_ff inside {[8'h08:8'h0f]}
      |-> so_out == CFG_BYTE[3'h7 - nbit_ff[2:0]]) else $error("config bit wrong");
   a_cfg_repeat: assert property (@(posedge sclk) disable iff (rst || select_n)
      op_ff == CONFIG_READ_CMD && nbit_ff >= 8'h10 |-> so_out == $past(so_out, 8))
      else $error("config byte not repeated");
   a_id_value: assert property (@(posedge sclk) disable iff (rst || select_n)
      op_ff == IDENTITY_READ_CMD && so_oe && nbit_ff inside {[8'h08:8'h1f]}
      |-> so_out == ID_CODE[5'h1f - nbit_ff[4:0]]) else $error("identity bit wrong");
   a_oe_holds: assert property (@(posedge sclk) disable iff (rst || select_n)
      nbit_ff > 8'h08 && $past(so_oe) |-> so_oe) else $error("so_oe dropped in frame");
endmodule : fws_core_checker

bind fws_flash_core fws_core_checker #(.ID_CODE(ID_CODE), .CFG_BYTE(CFG_BYTE)) u_chk (
   .clk(clk), .rst(rst), .sclk(sclk), .select_n(select_n), .si(si),
   .upper_io_lines(upper_io_lines), .so_out(so_out), .so_oe(so_oe));

// ### verification/fws_host_model.sv
`timescale 1ns/1ns
module fws_host_model (
   output logic       sclk,
   output logic       select_n,
   output logic       si,
   output logic [2:0] upper_io_lines,
   input  wire logic  so_out,
   input  wire logic  so_oe
);
   logic write_protect_n;
   logic saw_oe;
   logic toggle;
   // unused upper lines flip every bit so the device must ignore them
   assign upper_io_lines = {toggle, write_protect_n, toggle};
   initial begin
      sclk            = 1'b0;
      select_n        = 1'b1;
      si              = 1'b0;
      write_protect_n = 1'b1;
      saw_oe          = 1'b0;
      toggle          = 1'b0;
   end

   // ----------------------------------------------------------------
   // one frame: ntx bits sent msb first, then nrx bits clocked in
   // ----------------------------------------------------------------
   task automatic frame(input logic [31:0] tx, input int ntx, input int nrx,
                        output logic [31:0] rx);
      rx       = 32'h0;
      saw_oe   = 1'b0;
      select_n = 1'b0;
      #100;
      for (int i = 0; i < ntx + nrx; i++) begin
         si     = (i < ntx) ? tx[31 - i] : ~si;
         toggle = ~toggle;
         #62 sclk = 1'b1;
         // a released output line floats to its pull-up
         rx     = {rx[30:0], so_oe ? so_out : 1'b1};
         saw_oe = saw_oe | so_oe;
         #63 sclk = 1'b0;
      end
      #60 select_n = 1'b1;
      si = ~si;
      #800;
   endtask : frame
endmodule : fws_host_model

// ### verification/tb.sv
`timescale 1ns/1ns
module tb;
   import fws_pkg::*;
   localparam logic [47:0] WR_CODES = {PAGE_PROGRAM_CMD, FOUR_KB_WIPE_CMD, HALF_BLOCK_WIPE_CMD,
                                       BLOCK_WIPE_CMD, CHIP_WIPE_CMD_A, CHIP_WIPE_CMD_B};
   logic        clk;
   logic        rst;
   logic        sclk;
   logic        select_n;
   logic        si;
   logic [2:0]  upper_io_lines;
   logic        so_out;
   logic        so_oe;
   logic [31:0] rx;
   int          num_errors;
   int          n_tests;

   fws_host_model host (.sclk(sclk), .select_n(select_n), .si(si),
      .upper_io_lines(upper_io_lines), .so_out(so_out), .so_oe(so_oe));
   // short busy spans keep the run brief but outlast a few status polls
   fws_flash_core #(.PE_CYCLES(200), .SW_CYCLES(60)) dut (.clk(clk), .rst(rst), .sclk(sclk),
      .select_n(select_n), .si(si), .upper_io_lines(upper_io_lines), .so_out(so_out),
      .so_oe(so_oe));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic cmd(input logic [7:0] c, input int nb = 8, input logic [23:0] arg = 24'h0);
      host.frame({c, arg}, nb, 0, rx);
   endtask : cmd

   task automatic chk_st(input string what, input logic [7:0] exp, input logic [7:0] m = 8'hff);
      host.frame({STATUS_READ_CMD, 24'h0}, 8, 8, rx);
      check(what, rx[7:0] & m, exp);
   endtask : chk_st

   task automatic wait_idle();
      int k;
      k = 0;
      do begin
         host.frame({STATUS_READ_CMD, 24'h0}, 8, 8, rx);
         k++;
      end while (rx[0] !== 1'b0 && k < 40);
      check("busy_flag end", rx[0], 1'b0);
   endtask : wait_idle

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      num_errors = 0;
      n_tests    = 0;
      rst        = 1'b1;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      chk_st("reset status", 8'h00);
      cmd(WRITE_LATCH_SET_CMD);
      host.frame({STATUS_READ_CMD, 24'h0}, 8, 16, rx);
      check("status repeat", rx[15:0], 16'h0202);
      cmd(WRITE_LATCH_CLEAR_CMD);
      chk_st("latch clear", 8'h00);
      host.frame({CONFIG_READ_CMD, 24'h0}, 8, 16, rx);
      check("config", rx[15:0], {CFG_BYTE_DEF, CFG_BYTE_DEF});
      host.frame({IDENTITY_READ_CMD, 24'h0}, 8, 24, rx);
      check("identity", rx[23:0], ID_CODE_DEF);
      check("so_oe after", so_oe, 1'b0);
      $display("test reads done");
      for (int k = 0; k < 6; k++) begin
         cmd(WR_CODES[47 - 8*k -: 8], (k < 4) ? 32 : 8, 24'h00_10_00);
         chk_st("no latch", 8'h00);
         cmd(WRITE_LATCH_SET_CMD);
         cmd(WR_CODES[47 - 8*k -: 8], (k < 4) ? 32 : 8, 24'h00_10_00);
         chk_st("busy", 8'h03);
         host.frame({IDENTITY_READ_CMD, 24'h0}, 8, 24, rx);
         check("identity busy", host.saw_oe, 1'b0);
         check("identity busy data", rx[23:0], 24'hff_ffff);
         host.frame({CONFIG_READ_CMD, 24'h0}, 8, 8, rx);
         check("config busy", rx[7:0], CFG_BYTE_DEF);
         chk_st("still busy", 8'h03);
         wait_idle();
         chk_st("op done", 8'h00);
      end
      $display("test program erase done");
      cmd(WRITE_LATCH_SET_CMD);
      cmd(STATUS_WRITE_CMD, 16, 24'hbf_00_00);
      chk_st("write busy", 8'h03, 8'h03);
      wait_idle();
      chk_st("status write", 8'hbc);
      cmd(WRITE_LATCH_SET_CMD);
      cmd(CHIP_WIPE_CMD_A);
      chk_st("protected wipe", 8'hbc);
      cmd(WRITE_LATCH_SET_CMD);
      cmd(STATUS_WRITE_CMD, 20, 24'h0);
      chk_st("partial write", 8'hbc, 8'hfd);
      host.write_protect_n = 1'b0;
      cmd(WRITE_LATCH_SET_CMD);
      cmd(STATUS_WRITE_CMD, 16, 24'h0);
      chk_st("locked write", 8'hbc, 8'hfd);
      host.write_protect_n = 1'b1;
      cmd(WRITE_LATCH_SET_CMD);
      cmd(STATUS_WRITE_CMD, 16, 24'h0);
      wait_idle();
      chk_st("unlocked write", 8'h00);
      $display("test status write done");
      cmd(WRITE_LATCH_SET_CMD);
      cmd(QUAD_PAGE_PROGRAM_CMD, 32, 24'h00_20_00);
      chk_st("quad off", 8'h00, 8'h01);
      cmd(WRITE_LATCH_SET_CMD);
      cmd(STATUS_WRITE_CMD, 16, 24'h40_00_00);
      wait_idle();
      cmd(WRITE_LATCH_SET_CMD);
      cmd(QUAD_PAGE_PROGRAM_CMD, 32, 24'h00_20_00);
      chk_st("quad on", 8'h43);
      wait_idle();
      $display("test quad done");
      cmd(WRITE_LATCH_SET_CMD);
      cmd(PAGE_PROGRAM_CMD, 32, 24'h00_30_00);
      cmd(RESET_ARM_CMD);
      chk_st("armed", 8'h43);
      cmd(RESET_GO_CMD);
      chk_st("reset skipped", 8'h43);
      cmd(RESET_ARM_CMD);
      cmd(RESET_GO_CMD);
      chk_st("soft reset", 8'h40);
      cmd(WRITE_LATCH_SET_CMD);
      cmd(FOUR_KB_WIPE_CMD, 32, 24'h00_40_00);
      cmd(SUSPEND_CMD_A);
      chk_st("suspend", 8'h40);
      cmd(WRITE_LATCH_SET_CMD);
      cmd(SECURITY_LOCK_WRITE_CMD);
      chk_st("lock write", 8'h40);
      $display("test reset suspend done");
      stop_test();
   end

   // the sequence needs well under a millisecond
   initial begin
      #2000000;
      num_errors++;
      stop_test();
   end
endmodule : tb
